// >>> include/ccg_map.svh
/*
  Address map, field positions, reset values and timing figures of the serial-port
  integrity and configuration guard.
  Assumes the includer is the ccg package or the guard module itself.
*/
`ifndef CCG_MAP_SVH
`define CCG_MAP_SVH

`define CCG_ADDR_LAST_DATA_WORD32    12'h423
`define CCG_ADDR_LAST_DATA_WORD16    12'h4ac
`define CCG_ADDR_LAST_COMMAND_HEADER 12'h4ae
`define CCG_ADDR_WRITE_LOCK          12'h4fc
`define CCG_ADDR_SECOND_STATUS       12'h4fd

`define CCG_HDR_ADDR_MSB  15
`define CCG_HDR_ADDR_LSB  4
`define CCG_HDR_READ_BIT  3

`define CCG_STAT_CHANGED_BIT 0
`define CCG_STAT_DONE_BIT    1

`define CCG_CRC_PRESET 16'hffff
`define CCG_CRC_POLY   16'h1021

`define CCG_LOCK_ON_CODE  32'h0000_3c64
`define CCG_LOCK_OFF_CODE 32'h0000_4ad1

`define CCG_TABLE_ENTRIES 26
`define CCG_OPT_COUNT     12

`define CCG_CLK_PERIOD_NS 25
`define CCG_PASS_TIME_NS  10800000

`endif

// >>> include/ccg_pkg.sv
/*
  Types of the serial-port integrity and configuration guard.
  Assumes ccg_map.svh is on the include path.
*/
`include "ccg_map.svh"

package ccg_pkg;

  typedef enum logic [1:0] {
    CCG_IDLE,
    CCG_ISSUE,
    CCG_FOLD,
    CCG_WAIT
  } ccg_cfg_e;

  // Transaction events handed over by the serial framer, all on clk
  typedef struct packed {
    logic        hdr_valid;
    logic [15:0] hdr;
    logic [31:0] rd_data;
    logic        rd_is32;
    logic        wr_valid;
    logic [31:0] wr_data;
    logic        wr_is32;
  } ccg_txn_s;

  typedef struct packed {
    logic [11:0] hdr_addr;
    logic        crc_app;
    logic [15:0] spi_crc;
    logic [15:0] ld16;
    logic [31:0] ld32;
    logic [15:0] lcmd;
    logic        lock;
    logic        wr_go;
    logic [11:0] wr_addr;
    logic [31:0] wr_data;
    logic        wr_is32;
    ccg_cfg_e    cfg;
    logic [5:0]  ent;
    logic [5:0]  sub;
    logic [11:0] cfg_addr;
    logic        cfg_is16;
    logic [15:0] run_crc;
    logic [15:0] result;
    logic        have_result;
    logic        forced;
    logic        changed;
    logic        done;
    logic [18:0] timer;
    logic        irq_n;
  } ccg_state_s;

endpackage

// >>> logic/ccg_guard.sv
/*
  Serial-port integrity and configuration guard: serial read CRC, verification
  registers, background configuration checksum and write lock.
  Assumes a serial framer on clk that pulses header and completed-write events,
  and a register file that answers cfg_rd_addr combinationally on cfg_rd_data.
*/
`timescale 1ns/1ps
`include "ccg_map.svh"

module ccg_guard #(
  parameter int unsigned PASS_CYCLES = `CCG_PASS_TIME_NS / `CCG_CLK_PERIOD_NS,
  parameter logic [143:0] OPT_ADDRS  = {12{12'h000}},
  parameter logic [11:0]  OPT_IS16   = 12'h000
) (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire ccg_pkg::ccg_txn_s txn,
  input  wire logic              burst_en,
  input  wire logic [3:0]        wave_burst_channel_select,
  input  wire logic [11:0]       checksum_option_enables,
  input  wire logic              force_update,
  input  wire logic              changed_irq_enable,
  input  wire logic [31:0]       cfg_rd_data,
  output logic                   crc_append,
  output logic [15:0]            serial_read_checksum,
  output logic [31:0]            last_data_word32,
  output logic [15:0]            last_data_word16,
  output logic [15:0]            last_command_header,
  output logic [15:0]            config_checksum_result,
  output logic [15:0]            second_status_register,
  output logic [15:0]            write_lock,
  output logic                   wr_commit,
  output logic [11:0]            wr_commit_addr,
  output logic [31:0]            wr_commit_data,
  output logic                   wr_commit_is32,
  output logic [11:0]            cfg_rd_addr,
  output logic                   second_interrupt_output_n
);

  ccg_pkg::ccg_state_s s;
  ccg_pkg::ccg_state_s next_s;

  function automatic logic [15:0] crc_fold(input logic [15:0] c_in,
                                           input logic [31:0] d,
                                           input logic        is16);
    logic [15:0] c;
    logic        fb;
    c = c_in;
    fb = 1'b0;
    for (int i = 31; i >= 0; i--) begin
      if (!is16 || i < 16) begin
        fb = d[i] ^ c[15];
        c = {c[14:0], 1'b0} ^ (fb ? `CCG_CRC_POLY : 16'h0000);
      end
    end
    return c;
  endfunction

  function automatic logic is_verif(input logic [11:0] a);
    return a == `CCG_ADDR_LAST_DATA_WORD32 || a == `CCG_ADDR_LAST_DATA_WORD16 ||
           a == `CCG_ADDR_LAST_COMMAND_HEADER;
  endfunction

  function automatic logic is_burst(input logic [11:0] a, input logic ben,
                                    input logic [3:0] ch);
    return (ben && ((a >= 12'h500 && a <= 12'h516) || (a >= 12'h600 && a <= 12'h63c) ||
                    (a >= 12'h680 && a <= 12'h6bc))) || (a >= 12'h800 && ch != 4'hf);
  endfunction

  function automatic logic is_crc_case(input logic [11:0] a, input logic ben,
                                       input logic [3:0] ch);
    return !ben && (a <= 12'h6ff || (a >= 12'h800 && ch == 4'hf));
  endfunction

  function automatic logic is_protected(input logic [11:0] a);
    return a <= 12'h0ff || (a >= 12'h400 && a <= 12'h4ff);
  endfunction

  // Fixed monitored order: {first address, register count, 16-bit}
  function automatic logic [18:0] table_entry(input logic [5:0] i);
    logic [18:0] e;
    e = 19'h00000;
    unique case (i)
      6'd0:  e = {12'h001, 6'd24, 1'b0};
      6'd1:  e = {12'h021, 6'd24, 1'b0};
      6'd2:  e = {12'h041, 6'd24, 1'b0};
      6'd3:  e = {12'h060, 6'd20, 1'b0};
      6'd4:  e = {12'h409, 6'd1,  1'b0};
      6'd5:  e = {12'h40f, 6'd1,  1'b0};
      6'd6:  e = {12'h420, 6'd3,  1'b0};
      6'd7:  e = {12'h424, 6'd1,  1'b0};
      6'd8:  e = {12'h470, 6'd6,  1'b0};
      6'd9:  e = {12'h480, 6'd2,  1'b1};
      6'd10: e = {12'h490, 6'd8,  1'b1};
      6'd11: e = {12'h499, 6'd1,  1'b1};
      6'd12: e = {12'h4af, 6'd4,  1'b1};
      6'd13: e = {12'h425, 6'd1,  1'b0};
      6'd14: e = {12'h4b8, 6'd2,  1'b1};
      6'd15: e = {12'h47d, 6'd1,  1'b0};
      6'd16: e = {12'h478, 6'd2,  1'b0};
      6'd17: e = {12'h4ef, 6'd1,  1'b1};
      6'd18: e = {12'h4ba, 6'd1,  1'b1};
      6'd19: e = {12'h47e, 6'd1,  1'b0};
      6'd20: e = {12'h000, 6'd1,  1'b0};
      6'd21: e = {12'h020, 6'd1,  1'b0};
      6'd22: e = {12'h040, 6'd1,  1'b0};
      6'd23: e = {12'h4b6, 6'd1,  1'b1};
      6'd24: e = {12'h4bf, 6'd1,  1'b1};
      6'd25: e = {12'h4b5, 6'd1,  1'b1};
      default: e = 19'h00000;
    endcase
    return e;
  endfunction

  logic [11:0] hdr_a;
  logic [18:0] ent_e;
  logic [3:0]  opt_i;
  logic        opt_phase;

  assign hdr_a     = txn.hdr[`CCG_HDR_ADDR_MSB:`CCG_HDR_ADDR_LSB];
  assign ent_e     = table_entry(s.ent);
  assign opt_phase = s.ent >= 6'(`CCG_TABLE_ENTRIES);
  assign opt_i     = 4'(s.ent - 6'(`CCG_TABLE_ENTRIES));

  always_comb begin
    logic        blocked;
    logic        last;
    logic [15:0] pass_crc;
    next_s = s;
    blocked = 1'b0;
    last = 1'b0;
    pass_crc = 16'h0000;
    next_s.wr_go = 1'b0;

    if (txn.hdr_valid) begin
      next_s.hdr_addr = hdr_a;
      next_s.crc_app  = 1'b0;
      if (!is_verif(hdr_a)) begin
        next_s.lcmd = {txn.hdr[15:3], 3'b000};
      end
      if (txn.hdr[`CCG_HDR_READ_BIT]) begin
        // Checksum covers the addressed word only, so burst words beyond it are not folded
        next_s.spi_crc = crc_fold(`CCG_CRC_PRESET, txn.rd_data, !txn.rd_is32);
        next_s.crc_app = is_crc_case(hdr_a, burst_en, wave_burst_channel_select);
        if (!is_verif(hdr_a) && !is_burst(hdr_a, burst_en, wave_burst_channel_select)) begin
          if (txn.rd_is32) begin
            next_s.ld32 = txn.rd_data;
          end else begin
            next_s.ld16 = txn.rd_data[15:0];
          end
        end
      end
    end

    // Write event arrives only once every data bit is in
    if (txn.wr_valid) begin
      blocked = s.lock && is_protected(s.hdr_addr) &&
                s.hdr_addr != `CCG_ADDR_WRITE_LOCK;
      if (!is_verif(s.hdr_addr)) begin
        if (txn.wr_is32) begin
          next_s.ld32 = txn.wr_data;
        end else begin
          next_s.ld16 = txn.wr_data[15:0];
        end
      end
      next_s.wr_go   = !blocked;
      next_s.wr_addr = s.hdr_addr;
      next_s.wr_data = txn.wr_data;
      next_s.wr_is32 = txn.wr_is32;
      if (s.hdr_addr == `CCG_ADDR_WRITE_LOCK) begin
        if (txn.wr_data == `CCG_LOCK_ON_CODE) begin
          next_s.lock = 1'b1;
        end else if (txn.wr_data == `CCG_LOCK_OFF_CODE) begin
          next_s.lock = 1'b0;
        end
      end
      if (s.hdr_addr == `CCG_ADDR_SECOND_STATUS) begin
        if (txn.wr_data[`CCG_STAT_CHANGED_BIT]) begin
          next_s.changed = 1'b0;
        end
        if (txn.wr_data[`CCG_STAT_DONE_BIT]) begin
          next_s.done = 1'b0;
        end
      end
    end

    // Pass length is fixed by the timer, not by how fast the words fold
    if (s.cfg != ccg_pkg::CCG_IDLE) begin
      next_s.timer = s.timer + 19'h00001;
    end
    if (force_update) begin
      next_s.forced = 1'b1;
    end

    unique case (s.cfg)
      ccg_pkg::CCG_IDLE: begin
        next_s.cfg     = ccg_pkg::CCG_ISSUE;
        next_s.ent     = 6'd0;
        next_s.sub     = 6'd0;
        next_s.timer   = 19'h00000;
        next_s.run_crc = `CCG_CRC_PRESET;
      end
      ccg_pkg::CCG_ISSUE: begin
        if (!opt_phase) begin
          next_s.cfg_addr = ent_e[18:7] + 12'(s.sub);
          next_s.cfg_is16 = ent_e[0];
          next_s.cfg      = ccg_pkg::CCG_FOLD;
        end else if (checksum_option_enables[opt_i]) begin
          next_s.cfg_addr = OPT_ADDRS[opt_i*12 +: 12];
          next_s.cfg_is16 = OPT_IS16[opt_i];
          next_s.cfg      = ccg_pkg::CCG_FOLD;
        end else if (opt_i == 4'(`CCG_OPT_COUNT - 1)) begin
          next_s.cfg = ccg_pkg::CCG_WAIT;
        end else begin
          next_s.ent = s.ent + 6'd1;
        end
      end
      ccg_pkg::CCG_FOLD: begin
        next_s.run_crc = crc_fold(s.run_crc, cfg_rd_data, s.cfg_is16);
        last = opt_phase || (s.sub + 6'd1 == ent_e[6:1]);
        next_s.sub = last ? 6'd0 : s.sub + 6'd1;
        if (last) begin
          next_s.ent = s.ent + 6'd1;
        end
        next_s.cfg = (last && opt_i == 4'(`CCG_OPT_COUNT - 1) && opt_phase) ?
                     ccg_pkg::CCG_WAIT : ccg_pkg::CCG_ISSUE;
      end
      ccg_pkg::CCG_WAIT: begin
        if (s.timer >= 19'(PASS_CYCLES - 1)) begin
          pass_crc = s.run_crc;
          next_s.result      = pass_crc;
          next_s.have_result = 1'b1;
          if (s.have_result && pass_crc != s.result) begin
            next_s.changed = 1'b1;
          end
          if (s.forced || force_update) begin
            next_s.done   = 1'b1;
            next_s.forced = 1'b0;
          end
          next_s.cfg = ccg_pkg::CCG_IDLE;
        end
      end
    endcase

    // A force restarts the pass except in CCG_WAIT, where the finished fold is kept and only marked forced
    if (force_update && s.cfg != ccg_pkg::CCG_WAIT) begin
      next_s.cfg = ccg_pkg::CCG_IDLE;
    end
    next_s.irq_n = !(next_s.changed && changed_irq_enable);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s         <= '0;
      s.spi_crc <= `CCG_CRC_PRESET;
      s.cfg     <= ccg_pkg::CCG_IDLE;
      s.irq_n   <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign crc_append                = s.crc_app;
  assign serial_read_checksum      = s.spi_crc;
  assign last_data_word32          = s.ld32;
  assign last_data_word16          = s.ld16;
  assign last_command_header       = s.lcmd;
  assign config_checksum_result    = s.result;
  assign second_status_register    = {14'h0000, s.done, s.changed};
  assign write_lock                = {15'h0000, s.lock};
  assign wr_commit                 = s.wr_go;
  assign wr_commit_addr            = s.wr_addr;
  assign wr_commit_data            = s.wr_data;
  assign wr_commit_is32            = s.wr_is32;
  assign cfg_rd_addr               = s.cfg_addr;
  assign second_interrupt_output_n = s.irq_n;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_lcmd_low_zero: assert property (last_command_header[2:0] == 3'b000)
    else $error("last command header low bits not zero");

  chk_read_updates_ld32: assert property (
    (txn.hdr_valid && txn.hdr[3] && txn.rd_is32 && !is_verif(hdr_a) &&
     !is_burst(hdr_a, burst_en, wave_burst_channel_select))
    |-> ##1 last_data_word32 == $past(txn.rd_data))
    else $error("32-bit last data not updated after read header");

  chk_verif_read_keep: assert property (
    (txn.hdr_valid && is_verif(hdr_a) && !txn.wr_valid)
    |=> $stable(last_command_header) && $stable(last_data_word16) && $stable(last_data_word32))
    else $error("verification registers changed by their own read");

  chk_crc_follows: assert property (
    (txn.hdr_valid && txn.hdr[3] && !burst_en && hdr_a <= 12'h6ff) |=> crc_append)
    else $error("CRC append missing for eligible read");

  chk_burst_no_crc: assert property (
    (txn.hdr_valid && txn.hdr[3] && hdr_a >= 12'h800 && wave_burst_channel_select != 4'hf)
    |=> !crc_append)
    else $error("CRC appended on burst read");

  chk_lock_blocks: assert property (
    (txn.wr_valid && write_lock[0] && s.hdr_addr <= 12'h0ff) |=> !wr_commit)
    else $error("write to locked range committed");

  chk_lock_engage: assert property (
    (txn.wr_valid && s.hdr_addr == `CCG_ADDR_WRITE_LOCK && txn.wr_data == 32'h0000_3c64)
    |=> write_lock == 16'h0001 ##1 (write_lock == 16'h0001 || $past(txn.wr_valid)))
    else $error("lock code did not engage lock");

  chk_no_early_commit: assert property (!txn.wr_valid |=> !wr_commit)
    else $error("write committed before data complete");

  chk_write_ld16: assert property (
    (txn.wr_valid && !txn.wr_is32 && !is_verif(s.hdr_addr) && !txn.hdr_valid)
    |=> last_data_word16 == $past(txn.wr_data[15:0]))
    else $error("16-bit last data not updated by write");

  chk_crc_stable: assert property (!(txn.hdr_valid && txn.hdr[3]) |=> $stable(serial_read_checksum))
    else $error("serial read checksum changed without a read");

  chk_lock_release: assert property (
    (txn.wr_valid && s.hdr_addr == `CCG_ADDR_WRITE_LOCK && txn.wr_data == 32'h0000_4ad1)
    |=> write_lock == 16'h0000)
    else $error("release code did not free the lock");

  chk_lock_reg_open: assert property (
    (txn.wr_valid && s.hdr_addr == `CCG_ADDR_WRITE_LOCK) |=> wr_commit)
    else $error("write to lock register refused");

  // Upper protected range holds the lock register itself, which must stay open
  chk_lock_upper: assert property (
    (txn.wr_valid && write_lock[0] && s.hdr_addr >= 12'h400 && s.hdr_addr <= 12'h4ff &&
     s.hdr_addr != `CCG_ADDR_WRITE_LOCK) |=> !wr_commit)
    else $error("write to locked upper range committed");

  chk_irq_follows: assert property (
    second_interrupt_output_n == !(second_status_register[0] && $past(changed_irq_enable)))
    else $error("interrupt output disagrees with changed flag");

  chk_changed_at_end: assert property (
    $rose(second_status_register[0]) |-> $past(s.cfg) == ccg_pkg::CCG_WAIT)
    else $error("changed flag set outside the end of a pass");

  chk_done_forced: assert property (
    $rose(second_status_register[1]) |-> $past(s.forced) || $past(force_update))
    else $error("done flag set without a forced pass");

  chk_pass_preset: assert property (
    (s.cfg == ccg_pkg::CCG_IDLE) |=> s.run_crc == `CCG_CRC_PRESET)
    else $error("checksum pass did not start from preset");

endmodule

// >>> tb/ccg_regfile.sv
/*
  Register file model that stands behind the guard: answers the checksum engine's
  reads at once and applies every committed write.
  Assumes clk and rst_n of the guard; 16-bit registers live in bits 15:0.
*/
`timescale 1ns/1ps

module ccg_regfile (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [11:0] cfg_rd_addr,
  output wire logic [31:0] cfg_rd_data,
  input  wire logic        wr_commit,
  input  wire logic [11:0] wr_commit_addr,
  input  wire logic [31:0] wr_commit_data,
  input  wire logic        wr_commit_is32
);
  logic [31:0] mem [0:4095];

  assign cfg_rd_data = mem[cfg_rd_addr];

  // Address-derived contents so every monitored register holds a distinct value
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 4096; i++) mem[i] <= {4'ha, i[11:0], ~i[15:0]};
    end else if (wr_commit) begin
      mem[wr_commit_addr] <= wr_commit_is32 ? wr_commit_data : {16'h0000, wr_commit_data[15:0]};
    end
  end
endmodule

// >>> tb/testbench.sv
/*
  Self-checking bench of the guard: serial reads, writes under the lock and the
  background configuration checksum, with queued expectations.
  Assumes the guard and the register file model; the pass is shortened to 400 cycles.
*/
`timescale 1ns/1ps

module testbench;
  localparam int PASS = 400;
  // Fixed monitored order: first address, register count, 16-bit flag
  localparam logic [11:0] T_ADDR[26] = '{12'h001, 12'h021, 12'h041, 12'h060, 12'h409, 12'h40f,
    12'h420, 12'h424, 12'h470, 12'h480, 12'h490, 12'h499, 12'h4af, 12'h425, 12'h4b8, 12'h47d,
    12'h478, 12'h4ef, 12'h4ba, 12'h47e, 12'h000, 12'h020, 12'h040, 12'h4b6, 12'h4bf, 12'h4b5};
  localparam int T_CNT[26] = '{24, 24, 24, 20, 1, 1, 3, 1, 6, 2, 8, 1, 4, 1, 2, 1, 2, 1, 1, 1,
    1, 1, 1, 1, 1, 1};
  localparam logic [0:25] T_16 = 26'b00000000011110100110000111;
  // Optional registers sit outside the fixed list so each one moves the result on its own
  localparam logic [143:0] OPTA = {12'h0ab, 12'h0aa, 12'h0a9, 12'h0a8, 12'h0a7, 12'h0a6,
    12'h0a5, 12'h0a4, 12'h0a3, 12'h0a2, 12'h0a1, 12'h0a0};
  localparam logic [11:0] OPTIS = 12'h0f0;
  typedef struct packed {
    logic [15:0] crc;
    logic        app;
    logic [15:0] ld16;
    logic [31:0] ld32;
    logic [15:0] lcmd;
  } ccg_rd_s;
  typedef struct packed {
    logic [11:0] addr;
    logic [31:0] data;
    logic        is32;
  } ccg_wr_s;

  logic              clk;
  logic              rst_n;
  ccg_pkg::ccg_txn_s txn;
  logic              burst_en;
  logic [3:0]        chan;
  logic [11:0]       opt_en;
  logic              force_update;
  logic              irq_en;
  logic [31:0]       cfg_rd_data;
  logic              crc_append;
  logic [15:0]       serial_read_checksum;
  logic [31:0]       last_data_word32;
  logic [15:0]       last_data_word16;
  logic [15:0]       last_command_header;
  logic [15:0]       config_checksum_result;
  logic [15:0]       status;
  logic [15:0]       write_lock;
  logic              wr_commit;
  logic [11:0]       wr_commit_addr;
  logic [31:0]       wr_commit_data;
  logic              wr_commit_is32;
  logic [11:0]       cfg_rd_addr;
  logic              irq_n;
  logic [31:0]       lfsr;
  logic [31:0]       e_ld32;
  logic [15:0]       e_ld16;
  logic [15:0]       e_lcmd;
  logic [15:0]       r1;
  ccg_rd_s           exp_rd[$];
  ccg_wr_s           exp_wr[$];
  int                fails;
  int                compares;
  logic [11:0]       raddr[12] = '{12'h000, 12'h4ff, 12'h500, 12'h516, 12'h6ff, 12'h700,
                                   12'h800, 12'hfff, 12'h423, 12'h4ac, 12'h4ae, 12'h63c};
  logic [11:0]       waddr[7] = '{12'h000, 12'h0ff, 12'h100, 12'h3ff, 12'h400, 12'h4ff, 12'h500};

  ccg_guard #(.PASS_CYCLES(PASS), .OPT_ADDRS(OPTA), .OPT_IS16(OPTIS)) dut (
    .clk(clk), .rst_n(rst_n), .txn(txn), .burst_en(burst_en),
    .wave_burst_channel_select(chan), .checksum_option_enables(opt_en),
    .force_update(force_update), .changed_irq_enable(irq_en), .cfg_rd_data(cfg_rd_data),
    .crc_append(crc_append), .serial_read_checksum(serial_read_checksum),
    .last_data_word32(last_data_word32), .last_data_word16(last_data_word16),
    .last_command_header(last_command_header), .config_checksum_result(config_checksum_result),
    .second_status_register(status), .write_lock(write_lock), .wr_commit(wr_commit),
    .wr_commit_addr(wr_commit_addr), .wr_commit_data(wr_commit_data),
    .wr_commit_is32(wr_commit_is32), .cfg_rd_addr(cfg_rd_addr),
    .second_interrupt_output_n(irq_n));

  ccg_regfile rf (
    .clk(clk), .rst_n(rst_n), .cfg_rd_addr(cfg_rd_addr), .cfg_rd_data(cfg_rd_data),
    .wr_commit(wr_commit), .wr_commit_addr(wr_commit_addr), .wr_commit_data(wr_commit_data),
    .wr_commit_is32(wr_commit_is32));

  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction

  // Bit-serial generator, first bit is the word's top bit
  function automatic logic [15:0] crc_of(logic [15:0] c0, logic [31:0] d, logic is32);
    logic [15:0] c;
    logic        fb;
    c = c0;
    for (int i = 31; i >= 0; i--) begin
      if (is32 || i < 16) begin
        fb = d[i] ^ c[15];
        c = {c[14:0], 1'b0} ^ (fb ? 16'h1021 : 16'h0000);
      end
    end
    return c;
  endfunction

  // Reference configuration checksum over the model's current contents
  function automatic logic [15:0] cfg_crc();
    logic [15:0] c;
    c = 16'hffff;
    for (int e = 0; e < 26; e++) begin
      for (int k = 0; k < T_CNT[e]; k++) c = crc_of(c, rf.mem[T_ADDR[e] + 12'(k)], !T_16[e]);
    end
    for (int k = 0; k < 12; k++) begin
      if (opt_en[k]) c = crc_of(c, rf.mem[OPTA[k*12 +: 12]], !OPTIS[k]);
    end
    return c;
  endfunction

  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      fails++;
      $display("unexpected %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic is32);
    logic        bc;
    logic        app;
    logic [31:0] t;
    if (!is32) d[31:16] = 16'h0000;
    bc = (burst_en && ((a >= 12'h500 && a <= 12'h516) || (a >= 12'h600 && a <= 12'h63c)
         || (a >= 12'h680 && a <= 12'h6bc))) || (a >= 12'h800 && chan != 4'hf);
    app = !burst_en && (a <= 12'h6ff || (a >= 12'h800 && chan == 4'hf));
    if (!(a inside {12'h423, 12'h4ac, 12'h4ae})) begin
      e_lcmd = {a, 4'h8};
      if (!bc && is32) e_ld32 = d;
      if (!bc && !is32) e_ld16 = d[15:0];
    end
    exp_rd.push_back(ccg_rd_s'{crc_of(16'hffff, d, is32), app, e_ld16, e_ld32, e_lcmd});
    t = rnd();
    txn.hdr = {a, 1'b1, t[2:0]};
    txn.rd_data = d;
    txn.rd_is32 = is32;
    txn.hdr_valid = 1'b1;
    @(negedge clk);
    txn.hdr_valid = 1'b0;
    repeat (3) @(negedge clk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic is32);
    logic [31:0] t;
    logic        ok;
    if (!is32) d[31:16] = 16'h0000;
    ok = !(a <= 12'h0ff || (a >= 12'h400 && a <= 12'h4ff)) || write_lock !== 16'h0001
         || a == 12'h4fc;
    if (ok) exp_wr.push_back(ccg_wr_s'{a, d, is32});
    if (is32) e_ld32 = d;
    else e_ld16 = d[15:0];
    if (!(a inside {12'h423, 12'h4ac, 12'h4ae})) e_lcmd = {a, 4'h0};
    t = rnd();
    txn.hdr = {a, 1'b0, t[2:0]};
    txn.hdr_valid = 1'b1;
    @(negedge clk);
    txn.hdr_valid = 1'b0;
    txn.wr_data = d;
    txn.wr_is32 = is32;
    txn.wr_valid = 1'b1;
    @(negedge clk);
    txn.wr_valid = 1'b0;
    repeat (2) @(negedge clk);
    chk("last data 32", e_ld32, last_data_word32);
    chk("last data 16", {16'h0000, e_ld16}, {16'h0000, last_data_word16});
    chk("last header", {16'h0000, a, 4'h0}, {16'h0000, last_command_header});
  endtask

  task automatic wait_flag(input int b, input int lim);
    for (int i = 0; i < lim && status[b] !== 1'b1; i++) @(negedge clk);
    chk("status flag", 32'h1, {31'h0, status[b]});
  endtask

  task automatic stop_test();
    chk("pending writes", 32'h0, exp_wr.size());
    chk("pending reads", 32'h0, exp_rd.size());
    $display("fails %0d compares %0d", fails, compares);
    if (fails == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  initial begin
    ccg_rd_s r;
    forever begin
      @(posedge clk);
      if (txn.hdr_valid === 1'b1 && txn.hdr[3] === 1'b1) begin
        repeat (2) @(negedge clk);
        if (exp_rd.size() == 0) chk("read queue", 32'h1, 32'h0);
        else begin
          r = exp_rd.pop_front();
          chk("read crc", r.crc, serial_read_checksum);
          chk("crc append", r.app, crc_append);
          chk("last data 16", r.ld16, last_data_word16);
          chk("last data 32", r.ld32, last_data_word32);
          chk("last header", r.lcmd, last_command_header);
        end
      end
    end
  end

  initial begin
    ccg_wr_s w;
    forever begin
      @(posedge clk);
      #1;
      if (wr_commit === 1'b1) begin
        if (exp_wr.size() == 0) chk("refused write", 32'h0, {20'h0, wr_commit_addr});
        else begin
          w = exp_wr.pop_front();
          chk("commit addr", w.addr, wr_commit_addr);
          chk("commit data", w.data, wr_commit_data);
          chk("commit length", w.is32, wr_commit_is32);
        end
      end
    end
  end

  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    stop_test();
  end

  initial begin
    logic [31:0] t;
    lfsr = 32'hf5d69838;
    rst_n = 1'b0;
    txn = '0;
    burst_en = 1'b0;
    chan = 4'hf;
    force_update = 1'b0;
    irq_en = 1'b1;
    e_ld32 = '0;
    e_ld16 = '0;
    e_lcmd = '0;
    t = rnd();
    opt_en = t[11:0];
    repeat (5) @(negedge clk);
    chk("reset crc", 32'hffff, serial_read_checksum);
    chk("reset lock", 32'h0, write_lock);
    rst_n = 1'b1;
    for (int k = 0; k < 2; k++) begin
      foreach (raddr[i]) begin
        t = rnd();
        burst_en = t[4];
        chan = t[5] ? 4'hf : t[9:6];
        rd(raddr[i], rnd(), t[0]);
      end
    end
    burst_en = 1'b0;
    wr(12'h4fc, 32'h3c64, 1'b0);
    chk("lock on", 32'h1, write_lock);
    foreach (waddr[i]) wr(waddr[i], rnd(), 1'b1);
    wr(12'h4fc, 32'h4ad1, 1'b0);
    chk("lock off", 32'h0, write_lock);
    t = rnd();
    wr(12'h010, t, 1'b1);
    chk("read back", t, rf.mem[12'h010]);
    rd(12'h010, t, 1'b1);
    repeat (2 * PASS) @(negedge clk);
    wr(12'h4fd, 32'h3, 1'b0);
    repeat (2 * PASS) @(negedge clk);
    chk("quiet status", 32'h0, {16'h0, status});
    chk("config checksum", {16'h0, cfg_crc()}, {16'h0, config_checksum_result});
    r1 = config_checksum_result;
    wr(12'h005, rnd(), 1'b1);
    wait_flag(0, 2 * PASS + 50);
    chk("result moved", 32'h1, {31'h0, config_checksum_result !== r1});
    chk("irq low", 32'h0, {31'h0, irq_n});
    irq_en = 1'b0;
    repeat (3) @(negedge clk);
    chk("irq masked", 32'h1, {31'h0, irq_n});
    wr(12'h4fd, 32'h3, 1'b0);
    force_update = 1'b1;
    @(negedge clk);
    force_update = 1'b0;
    wait_flag(1, PASS + 50);
    chk("no change", 32'h0, {31'h0, status[0]});
    chk("forced checksum", {16'h0, cfg_crc()}, {16'h0, config_checksum_result});
    stop_test();
  end
endmodule
